// ===== src/apdr_core.sv
// hard reset handling and inter-channel phase delay generator of a two-channel converter
`timescale 1ns/100ps
`include "apdr_consts.svh"

module apdr_core
  import apdr_pkg::*;
#(
  parameter int TIME_W = `APDR_TIME_W
)(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // hard reset pin, asynchronous
  input  wire logic                   resetPinN,
  // serial-side register writes
  input  wire logic                   phaseWrEn,
  input  wire logic [11:0]            phaseWrData,
  input  wire logic                   cfgWrEn,
  input  wire apdr_cfg_t              cfgWrData,
  // register readback
  output logic [11:0]                 phaseRd,
  output apdr_cfg_t                   cfgRd,
  // modulator comparator codes and control
  input  wire logic [3:0]             refCompIn,
  input  wire logic [3:0]             shfCompIn,
  output logic [3:0]                  refCompOut,
  output logic [3:0]                  shfCompOut,
  output logic                        modClear,
  // filter results
  output apdr_codes_t                 codesOut,
  // pins toward the host
  input  wire logic                   sdoData,
  output logic                        sdoOut,
  output logic                        sdoOeN,
  output logic                        readyStrobeN,
  output logic                        readyOeN
);

  // reset release and pin synchronisers
  logic        rstMeta_r;
  logic        rstSync_r;
  logic        pinMeta_r;
  logic        pinSync_r;
  wire logic   pinLow = ~pinSync_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
      pinMeta_r <= 1'b0;
      pinSync_r <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
      pinMeta_r <= resetPinN;
      pinSync_r <= pinMeta_r;
    end
  end

  // control state
  apdr_state_t             state_r, state_nxt;
  logic [11:0]             phase_r, phase_nxt;
  apdr_cfg_t               cfg_r, cfg_nxt;
  logic [TIME_W-1:0]       time_r, time_nxt;
  logic                    refOn_r, refOn_nxt;
  logic                    shfOn_r, shfOn_nxt;
  logic                    restart;

  // derived timing
  logic [TIME_W-1:0]       halfRatio;
  logic [TIME_W-1:0]       ratioMask;
  logic [TIME_W-1:0]       phaseEff;
  logic [3:0]              signPos;
  logic [TIME_W-1:0]       dRef;
  logic [TIME_W-1:0]       dShf;
  logic                    refHit;
  logic                    shfHit;
  logic                    shfLeads;
  logic                    lagHit;

  assign signPos   = 4'(`APDR_RATIO_MIN_LOG - 1) + {1'b0, cfg_r.ratioSel};
  assign halfRatio = TIME_W'(1) << signPos;
  assign ratioMask = (TIME_W'(1) << (signPos + 4'h1)) - TIME_W'(1);

  // sign-extend from the active sign bit
  genvar gi;
  generate
    for (gi = 0; gi < TIME_W; gi++)
    begin : g_ext
      if (gi < `APDR_PHASE_W)
      begin : g_in
        assign phaseEff[gi] = (gi <= signPos) ? phase_r[gi] : phase_r[signPos];
      end
      else
      begin : g_sx
        assign phaseEff[gi] = phase_r[signPos];
      end
    end
  endgenerate

  // reference window fixed at half ratio from restart
  assign dRef = time_r - halfRatio;
  // positive phase delays the shifted window
  assign dShf = time_r - halfRatio - phaseEff;
  assign refHit = (state_r == ST_RUN) && ((dRef == '0) || (refOn_r && ((dRef & ratioMask) == '0)));
  assign shfHit = (state_r == ST_RUN) && ((dShf == '0) || (shfOn_r && ((dShf & ratioMask) == '0)));
  assign shfLeads = phaseEff[TIME_W-1];
  assign lagHit = shfLeads ? refHit : shfHit;

  // any phase write restarts, value compare not used
  assign restart = pinLow || (phaseWrEn && !pinLow);

  always_comb
  begin
    state_nxt = pinLow ? ST_HOLD : ST_RUN;
    phase_nxt = phase_r;
    cfg_nxt   = cfg_r;
    time_nxt  = time_r + TIME_W'(1);
    refOn_nxt = refOn_r | refHit;
    shfOn_nxt = shfOn_r | shfHit;
    case (state_r)
      ST_HOLD:
      begin
        // registers back to defaults while held
        phase_nxt = `APDR_PHASE_RST;
        cfg_nxt   = '{readyMergeMode: `APDR_MERGE_RST, ratioSel: `APDR_RATIO_SEL_RST};
      end
      ST_RUN:
      begin
        // writes only land outside hard reset
        if (phaseWrEn && !pinLow)
        begin
          phase_nxt = phaseWrData;
        end
        if (cfgWrEn && !pinLow)
        begin
          cfg_nxt = cfgWrData;
        end
      end
      default:
      begin
        state_nxt = ST_HOLD;
      end
    endcase
    // counter from release, restarted with the converters
    if (restart || (state_r != ST_RUN) || (cfgWrEn && !pinLow))
    begin
      time_nxt  = '0;
      refOn_nxt = 1'b0;
      shfOn_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      state_r <= ST_HOLD;
      phase_r <= `APDR_PHASE_RST;
      cfg_r   <= '{readyMergeMode: `APDR_MERGE_RST, ratioSel: `APDR_RATIO_SEL_RST};
      time_r  <= '0;
      refOn_r <= 1'b0;
      shfOn_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      cfg_r   <= cfg_nxt;
      time_r  <= time_nxt;
      refOn_r <= refOn_nxt;
      shfOn_r <= shfOn_nxt;
    end
  end

  // filter, double buffer and pins
  logic [`APDR_CODE_W-1:0] refAcc_r, refAcc_nxt;
  logic [`APDR_CODE_W-1:0] shfAcc_r, shfAcc_nxt;
  logic [`APDR_CODE_W-1:0] refBuf_r, refBuf_nxt;
  logic [`APDR_CODE_W-1:0] shfBuf_r, shfBuf_nxt;
  apdr_codes_t             codes_nxt;
  logic [3:0]              refComp_nxt;
  logic [3:0]              shfComp_nxt;
  logic                    modClear_nxt;
  logic                    readyN_nxt;
  logic                    oeN_nxt;
  logic                    sdo_nxt;
  logic                    holdNow;

  // restart acts at once so no stale window leaks into the first result
  assign holdNow = restart || (state_r != ST_RUN) || (cfgWrEn && !pinLow);

  always_comb
  begin
    // both channels integrate every cycle, only the windows differ
    refAcc_nxt   = refHit ? `APDR_CODE_W'(refCompOut) : refAcc_r + `APDR_CODE_W'(refCompOut);
    shfAcc_nxt   = shfHit ? `APDR_CODE_W'(shfCompOut) : shfAcc_r + `APDR_CODE_W'(shfCompOut);
    refBuf_nxt   = refHit ? refAcc_r : refBuf_r;
    shfBuf_nxt   = shfHit ? shfAcc_r : shfBuf_r;
    codes_nxt    = codesOut;
    readyN_nxt   = 1'b1;
    refComp_nxt  = refCompIn;
    shfComp_nxt  = shfCompIn;
    modClear_nxt = 1'b0;
    oeN_nxt      = 1'b0;
    sdo_nxt      = sdoData;
    if (cfg_r.readyMergeMode)
    begin
      // both latch and pulse on the lagging channel only
      if (lagHit)
      begin
        codes_nxt  = '{refCode: refBuf_nxt, shfCode: shfBuf_nxt};
        readyN_nxt = 1'b0;
      end
    end
    else
    begin
      // each channel pulses at its own window edge
      if (refHit)
      begin
        codes_nxt.refCode = refBuf_nxt;
      end
      if (shfHit)
      begin
        codes_nxt.shfCode = shfBuf_nxt;
      end
      readyN_nxt = ~(refHit | shfHit);
    end
    if (holdNow)
    begin
      refAcc_nxt = '0;
      shfAcc_nxt = '0;
      refBuf_nxt = '0;
      shfBuf_nxt = '0;
      readyN_nxt = 1'b1;
    end
    if (pinLow)
    begin
      // zero output code under hard reset
      codes_nxt    = '{refCode: `APDR_CODE_RST, shfCode: `APDR_CODE_RST};
      refComp_nxt  = `APDR_COMP_RST;
      shfComp_nxt  = `APDR_COMP_RST;
      modClear_nxt = 1'b1;
      oeN_nxt      = 1'b1;
      sdo_nxt      = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      refAcc_r     <= '0;
      shfAcc_r     <= '0;
      refBuf_r     <= '0;
      shfBuf_r     <= '0;
      codesOut     <= '{refCode: `APDR_CODE_RST, shfCode: `APDR_CODE_RST};
      refCompOut   <= `APDR_COMP_RST;
      shfCompOut   <= `APDR_COMP_RST;
      modClear     <= 1'b1;
      readyStrobeN <= 1'b1;
      readyOeN     <= 1'b1;
      sdoOut       <= 1'b0;
      sdoOeN       <= 1'b1;
      phaseRd      <= `APDR_PHASE_RST;
      cfgRd        <= '{readyMergeMode: `APDR_MERGE_RST, ratioSel: `APDR_RATIO_SEL_RST};
    end
    else
    begin
      refAcc_r     <= refAcc_nxt;
      shfAcc_r     <= shfAcc_nxt;
      refBuf_r     <= refBuf_nxt;
      shfBuf_r     <= shfBuf_nxt;
      codesOut     <= codes_nxt;
      refCompOut   <= refComp_nxt;
      shfCompOut   <= shfComp_nxt;
      modClear     <= modClear_nxt;
      readyStrobeN <= readyN_nxt;
      readyOeN     <= oeN_nxt;
      sdoOut       <= sdo_nxt;
      sdoOeN       <= oeN_nxt;
      phaseRd      <= phase_nxt;
      cfgRd        <= cfg_nxt;
    end
  end

  // checking helpers: cycles since restart or last reference edge, kept apart from the time counter
  logic [TIME_W-1:0] gapCnt_r;
  logic              refSeen_r;

  always_ff @(posedge clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      gapCnt_r  <= '0;
      refSeen_r <= 1'b0;
    end
    else
    begin
      gapCnt_r  <= holdNow ? '0 : (refHit ? TIME_W'(1) : gapCnt_r + TIME_W'(1));
      refSeen_r <= holdNow ? 1'b0 : (refSeen_r | refHit);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_r);

  chk_zero_code: assert property (pinLow |=> codesOut == '0)
    else $error("output code not zero under hard reset");
  chk_mod_clear: assert property (pinLow |=> modClear && time_r == '0)
    else $error("modulator not cleared under hard reset");
  chk_comp_pattern: assert property (pinLow |=> refCompOut == 4'h3 && shfCompOut == 4'h3)
    else $error("comparator pattern wrong under hard reset");
  chk_filter_clear: assert property (pinLow |=> refAcc_r == '0 && shfBuf_r == '0)
    else $error("filter state not cleared");
  chk_cfg_default: assert property (pinLow ##1 pinLow |=> phase_r == '0 && cfg_r.readyMergeMode)
    else $error("registers not back to defaults");
  chk_write_ignored: assert property (pinLow && phaseWrEn |=> phaseRd == `APDR_PHASE_RST || $stable(phaseRd))
    else $error("write taken during hard reset");
  chk_pins_released: assert property (pinLow |=> readyOeN && sdoOeN)
    else $error("output pins driven during hard reset");
  chk_first_ready: assert property (refHit && !refSeen_r |-> gapCnt_r == halfRatio)
    else $error("first reference window misplaced");
  chk_phase_gap: assert property (shfHit && refSeen_r && !shfLeads && phaseEff != '0 |-> gapCnt_r == phaseEff)
    else $error("ready gap differs from phase");
  chk_merge_only: assert property (cfg_r.readyMergeMode && !lagHit |=> readyStrobeN)
    else $error("non-lagging pulse in merge mode");
  chk_restart: assert property (phaseWrEn && !pinLow |=> time_r == '0 && !refOn_r)
    else $error("phase write did not restart");

  cov_merge_pulse: cover property (cfg_r.readyMergeMode && !readyStrobeN);
  cov_split_pulses: cover property (!cfg_r.readyMergeMode && refHit ##[1:64] shfHit);
  cov_lead_phase: cover property (shfLeads && shfHit);
  cov_pin_reset: cover property (pinLow ##1 !pinLow);

endmodule // apdr_core

// ===== src/apdr_consts.svh
// reset values, field positions and fixed codes of the phase delay block
`ifndef APDR_CONSTS_SVH
`define APDR_CONSTS_SVH

`define APDR_PHASE_W       12
`define APDR_PHASE_RST     12'h000
`define APDR_RATIO_SEL_W     3
`define APDR_RATIO_SEL_RST   3'h3
`define APDR_MERGE_RST       1'b1
`define APDR_RATIO_MIN_LOG   5
`define APDR_COMP_RST      4'h3
`define APDR_CODE_RST      24'h000000
`define APDR_CODE_W        24
`define APDR_TIME_W        13
`define APDR_CFG_MERGE_BIT 3

`endif

// ===== src/apdr_pkg.sv
// types shared by the phase delay and hard reset block
package apdr_pkg;

  // configuration word carried on the config write and readback ports
  typedef struct packed {
    logic       readyMergeMode;
    logic [2:0] ratioSel;
  } apdr_cfg_t;

  // one-hot control states
  typedef enum logic [1:0] {
    ST_HOLD = 2'b01,
    ST_RUN  = 2'b10
  } apdr_state_t;

  // per-channel filter output pair
  typedef struct packed {
    logic [23:0] refCode;
    logic [23:0] shfCode;
  } apdr_codes_t;

endpackage

// ===== tb/apdr_host_model.sv
// host side model: reset pin, register writes and ready pulse intake
`timescale 1ns/100ps
module apdr_host_model
  import apdr_pkg::*;
#(
  parameter int SETTLE = 64
)(
  // clock
  input  wire logic  clk,
  // pins toward the device
  output logic       resetPinN,
  output logic       phaseWrEn,
  output logic [11:0] phaseWrData,
  output logic       cfgWrEn,
  output apdr_cfg_t  cfgWrData,
  input  wire logic  readyStrobeN,
  // pulses kept after settling
  output int         keptPulses
);
  int settleCnt;

  initial
  begin
    resetPinN   = 1'b1;
    phaseWrEn   = 1'b0;
    phaseWrData = 12'h000;
    cfgWrEn     = 1'b0;
    cfgWrData   = apdr_cfg_t'(4'h0);
    keptPulses  = 0;
    settleCnt   = 0;
  end

  always @(posedge clk)
  begin
    if (!resetPinN || phaseWrEn || cfgWrEn)
      settleCnt <= 0;
    else if (settleCnt < SETTLE)
      settleCnt <= settleCnt + 1;
    else if (readyStrobeN === 1'b0)
      keptPulses <= keptPulses + 1;
  end

  // data line scrambled once released, so a stale value is never read as valid
  task automatic wrPhase(input logic [11:0] v);
  begin
    @(posedge clk);
    phaseWrEn   <= 1'b1;
    phaseWrData <= v;
    @(posedge clk);
    phaseWrEn   <= 1'b0;
    phaseWrData <= ~v;
  end
  endtask

  task automatic wrCfg(input apdr_cfg_t v);
  begin
    @(posedge clk);
    cfgWrEn   <= 1'b1;
    cfgWrData <= v;
    @(posedge clk);
    cfgWrEn   <= 1'b0;
    cfgWrData <= ~v;
  end
  endtask

  task automatic setPin(input logic lvl);
  begin
    @(posedge clk);
    resetPinN <= lvl;
  end
  endtask
endmodule // apdr_host_model

// ===== tb/adc_phase_delay_and_reset_bench.sv
// self-checking bench for the hard reset and phase delay core
`timescale 1ns/100ps
`include "apdr_consts.svh"
module adc_phase_delay_and_reset_bench
  import apdr_pkg::*;
;
  // negedges beyond the half-ratio wait from write edge to visible ready pulse at zero phase offset
  localparam int LAT = 2;
  logic clk, rst_n, resetPinN, phaseWrEn, cfgWrEn, modClear, sdoData, sdoOut, sdoOeN, readyStrobeN, readyOeN;
  logic [11:0] phaseWrData, phaseRd;
  logic [3:0]  refCompIn, shfCompIn, refCompOut, shfCompOut, prevRef, prevShf;
  apdr_cfg_t   cfgWrData, cfgRd;
  apdr_codes_t codesOut;
  logic        prevSdo;
  int          keptPulses, seed, miscompares, checked, t1, t2, k;
  int          cSel[7] = '{3, 0, 0, 1, 1, 2, 2};
  int          cMrg[7] = '{0, 0, 0, 1, 1, 0, 1};
  int          cPh[7]  = '{0, -16, 15, -32, 31, -1, 1};

  apdr_core dut_u (.clk(clk), .rst_n(rst_n), .resetPinN(resetPinN), .phaseWrEn(phaseWrEn),
    .phaseWrData(phaseWrData), .cfgWrEn(cfgWrEn), .cfgWrData(cfgWrData), .phaseRd(phaseRd), .cfgRd(cfgRd),
    .refCompIn(refCompIn), .shfCompIn(shfCompIn), .refCompOut(refCompOut), .shfCompOut(shfCompOut),
    .modClear(modClear), .codesOut(codesOut), .sdoData(sdoData), .sdoOut(sdoOut), .sdoOeN(sdoOeN),
    .readyStrobeN(readyStrobeN), .readyOeN(readyOeN));
  apdr_host_model host_u (.clk(clk), .resetPinN(resetPinN), .phaseWrEn(phaseWrEn), .phaseWrData(phaseWrData),
    .cfgWrEn(cfgWrEn), .cfgWrData(cfgWrData), .readyStrobeN(readyStrobeN), .keptPulses(keptPulses));

  always #20 clk = ~clk;

  always @(posedge clk)
  begin
    prevRef   <= refCompIn;
    prevShf   <= shfCompIn;
    prevSdo   <= sdoData;
    refCompIn <= 4'($random(seed));
    shfCompIn <= 4'($random(seed));
    sdoData   <= 1'($random(seed));
  end

  task automatic close_out;
  begin
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
  begin
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask

  // first and second ready pulse, in negedges after the current edge
  task automatic measure(input int lim, output int a, output int b);
    int n;
  begin
    a = -1;
    b = -1;
    for (n = 1; n <= lim; n++)
    begin
      @(negedge clk);
      if (readyStrobeN === 1'b0 && a >= 0 && b < 0)
        b = n;
      if (readyStrobeN === 1'b0 && a < 0)
        a = n;
    end
  end
  endtask

  function automatic int expFirst(input int r, input int mrg, input int p);
    return r / 2 + LAT + (mrg != 0 ? (p > 0 ? p : 0) : (p < 0 ? p : 0));
  endfunction

  task automatic phase_case(input int sel, input int mrg, input int p);
    int r;
  begin
    r = 32 << sel;
    host_u.wrCfg(apdr_cfg_t'({1'(mrg), 3'(sel)}));
    host_u.wrPhase(12'(p));
    measure(2 * r + 8, t1, t2);
    check("first ready", 48'(t1), 48'(expFirst(r, mrg, p)));
    if (mrg != 0 || p == 0)
      check("next ready", 48'(t2), 48'(t1 + r));
    else
      check("ready gap", 48'(t2), 48'(t1 + (p < 0 ? -p : p)));
    check("phase readback", 48'(phaseRd), {36'h0, 12'(p)});
    check("cfg readback", 48'(cfgRd), 48'({1'(mrg), 3'(sel)}));
    @(negedge clk);
    check("ref comparator", 48'(refCompOut), 48'(prevRef));
    check("shf comparator", 48'(shfCompOut), 48'(prevShf));
    check("sdo enable", 48'(sdoOeN), 48'd0);
    check("sdo copy", 48'(sdoOut), 48'(prevSdo));
  end
  endtask

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    seed = 25;
    miscompares = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    measure(300, t1, t2);
    check("power-on ready", 48'(t1 > 0), 48'd1);
    check("phase default", 48'(phaseRd), 48'(`APDR_PHASE_RST));
    check("cfg default", 48'(cfgRd), 48'({`APDR_MERGE_RST, `APDR_RATIO_SEL_RST}));
    for (k = 0; k < 7; k++)
      phase_case(cSel[k], cMrg[k], cPh[k]);
    for (k = 0; k < 8; k++)
      phase_case(k & 3, k & 1, ($random(seed) & ((32 << (k & 3)) - 1)) - (16 << (k & 3)));
    // same value rewritten must restart timing again
    host_u.wrPhase(12'hfff);
    repeat (50) @(negedge clk);
    host_u.wrPhase(12'hfff);
    measure(300, t1, t2);
    check("rewrite restart", 48'(t1), 48'(expFirst(256, 1, -1)));
    host_u.wrPhase(12'h010);
    host_u.setPin(1'b0);
    repeat (5) @(negedge clk);
    check("modulator clear", 48'(modClear), 48'd1);
    check("ref comp forced", 48'(refCompOut), 48'(`APDR_COMP_RST));
    check("shf comp forced", 48'(shfCompOut), 48'(`APDR_COMP_RST));
    check("codes zero", 48'(codesOut), 48'd0);
    check("sdo released", 48'(sdoOeN), 48'd1);
    check("ready released", 48'(readyOeN), 48'd1);
    host_u.wrPhase(12'h020);
    measure(300, t1, t2);
    check("no pulses held", 48'(t1), 48'(-1));
    host_u.setPin(1'b1);
    repeat (5) @(negedge clk);
    check("phase after pin", 48'(phaseRd), 48'(`APDR_PHASE_RST));
    check("cfg after pin", 48'(cfgRd), 48'({`APDR_MERGE_RST, `APDR_RATIO_SEL_RST}));
    check("ready driven", 48'(readyOeN), 48'd0);
    check("settled pulses", 48'(keptPulses > 0), 48'd1);
    close_out();
  end

  // bounded run, well past the longest expected sequence
  initial
  begin
    #2400000;
    miscompares++;
    close_out();
  end
endmodule // adc_phase_delay_and_reset_bench
